/* File: rtl/stc_pkg.sv */
// Purpose: Shared constants and types for the serial transmit control block
// Assumes: APB slave with 32-bit data, one clock at 250 MHz
// Notes: Offsets are byte addresses
package stc_pkg;
  localparam logic [11:0] STC_CTRL_OFS = 12'h000;
  localparam logic [11:0] STC_DATA_OFS = 12'h004;
  localparam logic [11:0] STC_STAT_OFS = 12'h008;
  localparam logic [11:0] STC_IRQ_OFS = 12'h00c;
  localparam logic [11:0] STC_MASK_OFS = 12'h010;
  localparam logic [11:0] STC_DIV_OFS = 12'h014;
  // Control field positions
  localparam int STC_LINK_SYNC_BIT = 4;
  localparam int STC_BREAK_BIT = 3;
  localparam int STC_FAST_BIT = 2;
  localparam int STC_EMPTY_BIT = 1;
  localparam int STC_NINTH_BIT = 0;
  localparam int STC_NINE_EN_BIT = 6;
  localparam int STC_TX_EN_BIT = 5;
  // Interrupt status bits
  localparam int STC_IRQ_DONE_BIT = 0;
  localparam int STC_IRQ_BREAK_BIT = 1;
  localparam logic [7:0] STC_CTRL_RST = 8'h02;
  localparam logic [15:0] STC_DIV_RST = 16'h0019;
  // Low speed multiplies the divisor by a further factor
  localparam int STC_SLOW_FACTOR = 4;
  localparam int STC_FAST_FACTOR = 1;
  localparam int STC_BREAK_BITS = 13;
  localparam int STC_CHAR_BITS = 11;
  typedef enum logic [1:0] {
    STC_IDLE = 2'b00,
    STC_LOAD = 2'b01,
    STC_SHIFT = 2'b10
  } stc_state_t;
  typedef struct packed {
    logic sync_mode;
    logic fast_rate;
    logic nine_bit;
  } stc_cfg_t;
endpackage : stc_pkg

/* File: rtl/stc_baud.sv */
// Purpose: Bit-rate enable generator for the transmit shifter
// Assumes: Divisor and fast select stable while shifter is running
// Notes: Emits one-cycle tick pulses
`timescale 1ns/1ps
`default_nettype none
module stc_baud
  import stc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire stc_cfg_t cfg,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  initial begin
    if (DIV_W < 2) $error("stc_baud: DIV_W too small");
  end
  logic [DIV_W+1:0] cnt_r, cnt_nxt, limit;
  logic tick_nxt;
  always_comb begin
    // Sync mode ignores the rate select
    if (cfg.sync_mode || cfg.fast_rate)
      limit = {2'b00, divisor} * (DIV_W+2)'(STC_FAST_FACTOR);
    else
      limit = {2'b00, divisor} * (DIV_W+2)'(STC_SLOW_FACTOR);
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r >= limit) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + (DIV_W+2)'(1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule : stc_baud
`default_nettype wire

/* File: rtl/stc_tx.sv */
// Purpose: Transmit control, status and shifter of a serial transceiver
// Assumes: APB slave, one clock, synchronous pin inputs
// Notes: Notes on behaviour follow
`timescale 1ns/1ps
`default_nettype none
module stc_tx
  import stc_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_out,
  output logic sclk_out,
  output logic irq
);
  initial begin
    if (DIV_W < 2 || DIV_W > 16) $error("stc_tx: DIV_W out of range");
  end

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] data_r, data_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;
  stc_state_t st_r, st_nxt;
  logic [13:0] shift_r, shift_nxt;
  logic [3:0] left_r, left_nxt;
  logic brk_r, brk_nxt;
  logic tx_nxt, sclk_nxt, empty;
  logic tick, run;
  stc_cfg_t cfg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Setup cycle answers are never given; pready rises in the access phase
  logic acc, wr, rd;
  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  assign cfg.sync_mode = ctrl_r[STC_LINK_SYNC_BIT];
  assign cfg.fast_rate = ctrl_r[STC_FAST_BIT];
  assign cfg.nine_bit = ctrl_r[STC_NINE_EN_BIT];
  assign empty = (st_r == STC_IDLE);
  assign run = (st_r == STC_SHIFT);

  stc_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk(clk),
    .rstn(rstn),
    .run(run),
    .cfg(cfg),
    .divisor(div_r),
    .tick(tick)
  );

  // Shifter and events
  logic done_ev, brk_ev, start;
  logic data_pend_r, data_pend_nxt;
  always_comb begin
    st_nxt = st_r;
    shift_nxt = shift_r;
    left_nxt = left_r;
    brk_nxt = brk_r;
    done_ev = 1'b0;
    brk_ev = 1'b0;
    start = 1'b0;
    case (st_r)
      STC_IDLE: begin
        if (data_pend_r && ctrl_r[STC_TX_EN_BIT]) begin
          st_nxt = STC_LOAD;
          start = 1'b1;
        end
      end
      STC_LOAD: begin
        // Break only in asynchronous mode
        brk_nxt = ctrl_r[STC_BREAK_BIT] && !cfg.sync_mode;
        if (ctrl_r[STC_BREAK_BIT] && !cfg.sync_mode) begin
          shift_nxt = {1'b1, 13'h0000};
          left_nxt = 4'(STC_BREAK_BITS + 1);
        end else if (cfg.sync_mode) begin
          // no start or stop framing in synchronous mode
          shift_nxt = {5'h1f, ctrl_r[STC_NINTH_BIT], data_r};
          left_nxt = cfg.nine_bit ? 4'd9 : 4'd8;
        end else begin
          // ninth bit follows the eight data bits
          shift_nxt = cfg.nine_bit ? {4'hf, ctrl_r[STC_NINTH_BIT], data_r, 1'b0}
                                   : {4'hf, 1'b1, data_r, 1'b0};
          left_nxt = cfg.nine_bit ? 4'(STC_CHAR_BITS) : 4'(STC_CHAR_BITS - 1);
        end
        st_nxt = STC_SHIFT;
      end
      STC_SHIFT: begin
        if (tick) begin
          shift_nxt = {1'b1, shift_r[13:1]};
          left_nxt = left_r - 4'd1;
          if (left_r == 4'd1) begin
            st_nxt = STC_IDLE;
            done_ev = 1'b1;
            brk_ev = brk_r;
            brk_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = STC_IDLE;
    endcase
    tx_nxt = run ? shift_r[0] : 1'b1;
    // Sync clock goes low for one clock cycle on each bit tick; only meaningful in sync mode
    sclk_nxt = !(run && cfg.sync_mode && tick);
  end

  // Register file
  always_comb begin
    ctrl_nxt = ctrl_r;
    data_nxt = data_r;
    div_nxt = div_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    data_pend_nxt = data_pend_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = acc;
    if (start) data_pend_nxt = 1'b0;
    if (wr) begin
      if (hit(paddr, STC_CTRL_OFS)) begin
        // fields take effect on the next clock edge; empty flag read-only
        ctrl_nxt = pwdata[7:0] & ~(8'h01 << STC_EMPTY_BIT);
      end else if (hit(paddr, STC_DATA_OFS)) begin
        data_nxt = pwdata[7:0];
        data_pend_nxt = 1'b1;
      end else if (hit(paddr, STC_IRQ_OFS)) begin
        stat_nxt = stat_r & ~pwdata[1:0];
      end else if (hit(paddr, STC_MASK_OFS)) begin
        mask_nxt = pwdata[1:0];
      end else if (hit(paddr, STC_DIV_OFS)) begin
        div_nxt = pwdata[DIV_W-1:0];
      end else if (!hit(paddr, STC_STAT_OFS)) begin
        pslverr_nxt = 1'b1;
      end
    end else if (rd) begin
      if (hit(paddr, STC_CTRL_OFS)) begin
        prdata_nxt = {24'h000000, ctrl_r | ({7'h00, empty} << STC_EMPTY_BIT)};
      end else if (hit(paddr, STC_DATA_OFS)) begin
        prdata_nxt = {24'h000000, data_r};
      end else if (hit(paddr, STC_STAT_OFS)) begin
        prdata_nxt = {29'h00000000, data_pend_r, st_r};
      end else if (hit(paddr, STC_IRQ_OFS)) begin
        prdata_nxt = {30'h00000000, stat_r};
      end else if (hit(paddr, STC_MASK_OFS)) begin
        prdata_nxt = {30'h00000000, mask_r};
      end else if (hit(paddr, STC_DIV_OFS)) begin
        prdata_nxt = {{(32-DIV_W){1'b0}}, div_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    // Hardware clear of the break request at break end
    if (brk_ev) ctrl_nxt[STC_BREAK_BIT] = 1'b0;
    // Set wins over a same-cycle clear
    if (done_ev) stat_nxt[STC_IRQ_DONE_BIT] = 1'b1;
    if (brk_ev) stat_nxt[STC_IRQ_BREAK_BIT] = 1'b1;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= STC_CTRL_RST & ~(8'h01 << STC_EMPTY_BIT);
      data_r <= 8'h00;
      div_r <= STC_DIV_RST[DIV_W-1:0];
      stat_r <= 2'b00;
      mask_r <= 2'b00;
      data_pend_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      st_r <= STC_IDLE;
      shift_r <= 14'h3fff;
      left_r <= 4'h0;
      brk_r <= 1'b0;
      tx_out <= 1'b1;
      sclk_out <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      data_r <= data_nxt;
      div_r <= div_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      data_pend_r <= data_pend_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
      st_r <= st_nxt;
      shift_r <= shift_nxt;
      left_r <= left_nxt;
      brk_r <= brk_nxt;
      tx_out <= tx_nxt;
      sclk_out <= sclk_nxt;
    end
  end
endmodule : stc_tx
`default_nettype wire

/* File: test/stc_tx_monitor.sv */
// Purpose: Port checker for stc_tx
// Assumes: One clock, rstn async low
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module stc_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_out,
  input wire logic sclk_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdy_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_rdy_answers_req: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_rdy_only_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_with_rdy: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error read not zero");
  a_sclk_one_low: assert property (!sclk_out |=> sclk_out) else $error("sclk low too long");
  a_line_idle_rst: assert property ($rose(rstn) |-> tx_out && sclk_out) else $error("line not idle");
  cover property (pslverr);
  cover property (!sclk_out);
  cover property ($fell(tx_out));
endmodule : stc_chk
bind stc_tx stc_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .sclk_out(sclk_out));
`default_nettype wire

/* File: test/stc_line_rx.sv */
// Purpose: Far-side line receiver model
// Assumes: Bit period given in clocks
// Notes: No resync, so a wrong period shows
`timescale 1ns/1ps
`default_nettype none
module stc_line_rx (
  input wire logic clk,
  input wire logic tx_out,
  input wire logic sclk_out,
  input wire logic [7:0] per,
  input wire logic [7:0] nb,
  output logic [13:0] frame,
  output var int got,
  output var int ticks
);
  always begin
    @(posedge clk iff tx_out === 1'b0);
    frame = '1;
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      frame[i] = tx_out;
      repeat (per) @(posedge clk);
    end
    got++;
  end
  always @(negedge sclk_out) ticks++;
endmodule : stc_line_rx
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for stc_tx
// Assumes: DIV set to 1 for short bit periods
// Notes: Line receiver model decodes frames
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stc_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, tx_out, sclk_out, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] per, nb;
  logic [13:0] frame;
  int got, ticks, num_errors, compares, n, g0;
  stc_tx dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_out(tx_out),
    .sclk_out(sclk_out), .irq(irq));
  stc_line_rx rx (.clk(clk), .tx_out(tx_out), .sclk_out(sclk_out), .per(per), .nb(nb),
    .frame(frame), .got(got), .ticks(ticks));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] v, input logic [31:0] x);
    compares++;
    if (v !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, v, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for both the done interrupt and the far side's decode
  task automatic send(input logic [31:0] c, input logic [7:0] d, input logic [13:0] f);
    g0 = got;
    apb(1'b1, STC_CTRL_OFS, c);
    apb(1'b1, STC_DATA_OFS, {24'h0, d});
    apb(1'b0, STC_CTRL_OFS, 32'h0);
    chk(q & 32'h2, 32'h0);
    for (n = 0; n < 500 && (irq !== 1'b1 || got == g0); n++) @(posedge clk);
    if (n == 500) begin
      num_errors++;
      summarize();
    end
    apb(1'b1, STC_IRQ_OFS, 32'h3);
    apb(1'b0, STC_CTRL_OFS, 32'h0);
    chk(q & 32'ha, 32'h2);
    chk({31'h0, irq}, 32'h0);
    chk({18'h0, frame}, {18'h0, f});
  endtask : send
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    per = 8'h2;
    nb = 8'ha;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, STC_CTRL_OFS, 32'h0);
    chk(q, {24'h0, STC_CTRL_RST});
    apb(1'b0, STC_DIV_OFS, 32'h0);
    chk(q, {16'h0, STC_DIV_RST});
    apb(1'b1, STC_CTRL_OFS, 32'h0);
    apb(1'b0, STC_CTRL_OFS, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, STC_DIV_OFS, 32'h1);
    apb(1'b1, STC_MASK_OFS, 32'h1);
    send(32'h24, 8'ha5, {5'h1f, 8'ha5, 1'b0});
    per = 8'h5;
    send(32'h20, 8'ha5, {5'h1f, 8'ha5, 1'b0});
    per = 8'h2;
    nb = 8'hb;
    send(32'h64, 8'h5a, {4'hf, 1'b0, 8'h5a, 1'b0});
    nb = 8'he;
    send(32'h2c, 8'h00, {1'b1, 13'h0});
    // Masked: status must stick while irq stays low
    apb(1'b1, STC_MASK_OFS, 32'h0);
    g0 = ticks;
    apb(1'b1, STC_CTRL_OFS, 32'h38);
    apb(1'b1, STC_DATA_OFS, 32'h5a);
    q = '0;
    for (int i = 0; i < 100 && q[1] !== 1'b1; i++) apb(1'b0, STC_CTRL_OFS, 32'h0);
    chk(ticks - g0, 32'h8);
    chk(q & 32'ha, 32'ha);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, STC_IRQ_OFS, 32'h0);
    chk(q & 32'h1, 32'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
